// ==== rtl/hb_pkg.sv ====
// constants, state types and rule overview for the host bus port
// Overview of operation
// RL1 - read acknowledge waits for select and read low, after synchronizing
// RL2 - write acknowledge waits for select and write low, after synchronizing
// RL3 - host inserts wait states until the acknowledge goes low
// RL4 - a running DMA ownership finishes before any register access is acknowledged
// RL5 - select may lead or trail the strobe; delay counts from the later
// RL6 - register select is decoded only when the acknowledge is asserted
// RL7 - select lines latch on address strobe fall, pass through while high
// RL8 - grant missed before first bus state slips the DMA four bus clocks
// RL9 - remote DMA does one transfer per ownership, local DMA bursts
// RL10 - 32-bit mode adds primed states only before the first burst transfer
// RL11 - byte mode keeps upper address driven through a burst, floats after
// RL12 - bus clock period 50 to 125 ns, faster than network side; ref_clk here runs at 25 ns
// RL13 - on dropping bus request, address and strobe outputs float
package hb_pkg;
    localparam int HB_RS_W = 4;
    localparam int HB_ADDR_W = 16;
    localparam int HB_DATA_W = 16;
    localparam int HB_FIFO_DEPTH = 16;
    localparam int HB_CLK_PERIOD_NS = 25;
    localparam int HB_BUS_PERIOD_MIN_NS = 50;
    localparam int HB_BUS_PERIOD_MAX_NS = 125;
    localparam logic [2:0] HB_SLIP_CYCLES = 3'h4;
    localparam logic [2:0] HB_PRIME_CYCLES = 3'h4;
    localparam logic [HB_RS_W-1:0] HB_RS_RST = 4'h0;
    localparam logic [HB_DATA_W-1:0] HB_DATA_RST = 16'h0000;

    typedef enum logic [1:0] {
        HB_S_IDLE, HB_S_SYNC, HB_S_DMA_WAIT, HB_S_ACK
    } hb_slave_state_t;

    typedef enum logic [3:0] {
        HB_D_IDLE, HB_D_REQ, HB_D_SLIP, HB_D_PRIME,
        HB_D_T1, HB_D_T2, HB_D_T3, HB_D_T4, HB_D_RELEASE
    } hb_dma_state_t;
endpackage

// ==== rtl/hb_fifo_if.sv ====
// handshake bundle between the transfer engine and its data FIFO
`timescale 1ns/1ps
interface hb_fifo_if #(parameter int WIDTH = 16);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    modport fifo (input in_valid, input in_data, input out_ready,
                  output in_ready, output out_valid, output out_data);
    modport user (output in_valid, output in_data, output out_ready,
                  input in_ready, input out_valid, input out_data);
endinterface

// ==== rtl/hb_fifo.sv ====
// flop-based FIFO holding network data until the DMA engine writes it out
`timescale 1ns/1ps
module hb_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    hb_fifo_if.fifo port
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = port.in_valid && port.in_ready && ce;
    wire pop = port.out_valid && port.out_ready && ce;

    // honest full and empty straight from the occupancy count
    assign port.in_ready = (count != DEPTH[AW:0]);
    assign port.out_valid = (count != '0);
    assign port.out_data = mem[rd_ptr];

    // storage has no reset; only pointers and count carry control state
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= port.in_data;
        end
    end

    // pointers wrap naturally since depth is a power of two
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(pop);
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ==== rtl/hb_host_port.sv ====
// host bus slave handshake and DMA bus master of the network controller
`timescale 1ns/1ps
module hb_host_port
    import hb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic chip_select_n,
    input wire logic slave_read_strobe_n,
    input wire logic slave_write_strobe_n,
    input wire logic address_strobe_in,
    input wire logic [HB_RS_W-1:0] register_select,
    output logic access_ack_n,
    output logic [HB_RS_W-1:0] latched_register_select,
    output logic [HB_RS_W-1:0] decoded_register,
    output logic reg_read_pulse,
    output logic reg_write_pulse,
    input wire logic net_valid,
    input wire logic [HB_DATA_W-1:0] net_data,
    output logic net_ready,
    input wire logic dma_local_req,
    input wire logic dma_remote_req,
    input wire logic mode_32bit,
    input wire logic byte_mode,
    input wire logic [HB_ADDR_W-1:0] dma_start_addr,
    output logic dma_done,
    input wire logic bus_grant,
    output logic bus_request_out,
    output logic addr_strobe_out_n,
    output logic mem_write_strobe_n,
    output logic ctrl_oe_n,
    output logic [HB_ADDR_W-1:0] dma_address,
    output logic lower_address_oe_n,
    output logic upper_address_lines_oe_n,
    output logic [HB_DATA_W-1:0] bus_data_out,
    output logic bus_data_oe_n
);
    ////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers
    logic [1:0] rst_pipe;
    logic rst_n;
    logic [HB_RS_W+4:0] pin_s1;
    logic [HB_RS_W+4:0] pin_s2;
    wire [HB_RS_W+4:0] pin_raw = {register_select, address_strobe_in,
        bus_grant, slave_write_strobe_n, slave_read_strobe_n, chip_select_n};
    assign rst_n = rst_pipe[1];

    // reset asserts at once, releases two edges later
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_pipe <= 2'h0;
        end else if (clk_en) begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    // idle pin levels on reset keep a false access from showing up
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 9'h017;
            pin_s2 <= 9'h017;
        end else if (clk_en) begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
        end
    end

    wire cs_s = !pin_s2[0];
    wire rd_s = !pin_s2[1];
    wire wr_s = !pin_s2[2];
    wire grant_s = pin_s2[3];
    wire ads_s = pin_s2[4];
    wire [HB_RS_W-1:0] rs_s = pin_s2[HB_RS_W+4:5];

    ////////////////////////////////////////////////////////////////////////
    // register select latch: follows while strobe high, holds after fall
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            latched_register_select <= HB_RS_RST;
        end else if (clk_en && ads_s) begin
            latched_register_select <= rs_s; // see RL7
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // slave access handshake
    hb_slave_state_t s_state;
    hb_slave_state_t next_s_state;
    hb_dma_state_t d_state;
    hb_dma_state_t next_d_state;
    logic dma_owned;
    // select and strobe may arrive in any order; the later one starts it
    wire access = cs_s && (rd_s || wr_s); // see RL5
    wire enter_ack = (next_s_state == HB_S_ACK) && (s_state != HB_S_ACK);
    // a bus cycle about to start counts as owned, so an ack never starts together with T1
    wire bus_busy = dma_owned ||
        (next_d_state inside {HB_D_PRIME, HB_D_T1}); // see RL4

    // one settling cycle, then wait for any ownership to end
    always_comb begin
        next_s_state = s_state;
        unique case (s_state)
            HB_S_IDLE: if (access) next_s_state = HB_S_SYNC;
            HB_S_SYNC: begin
                if (!access) begin
                    next_s_state = HB_S_IDLE;
                end else if (bus_busy) begin
                    next_s_state = HB_S_DMA_WAIT; // see RL4
                end else begin
                    next_s_state = HB_S_ACK; // see RL1 see RL2
                end
            end
            HB_S_DMA_WAIT: begin
                if (!access) begin
                    next_s_state = HB_S_IDLE;
                end else if (!bus_busy) begin
                    next_s_state = HB_S_ACK; // see RL4
                end
            end
            HB_S_ACK: if (!access) next_s_state = HB_S_IDLE; // see RL5
        endcase
    end

    // acknowledge and decode are taken together, never earlier
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_state <= HB_S_IDLE;
            access_ack_n <= 1'b1;
            decoded_register <= HB_RS_RST;
            reg_read_pulse <= 1'b0;
            reg_write_pulse <= 1'b0;
        end else if (clk_en) begin
            s_state <= next_s_state;
            access_ack_n <= (next_s_state != HB_S_ACK);
            reg_read_pulse <= enter_ack && rd_s;
            reg_write_pulse <= enter_ack && wr_s && !rd_s;
            if (enter_ack) begin
                decoded_register <= latched_register_select; // see RL6
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // DMA bus master
    hb_fifo_if #(.WIDTH(HB_DATA_W)) fq ();
    hb_fifo #(.WIDTH(HB_DATA_W), .DEPTH(HB_FIFO_DEPTH)) u_fifo (
        .clk(ref_clk),
        .rst_n(rst_n),
        .ce(clk_en),
        .port(fq.fifo)
    );
    assign fq.in_valid = net_valid;
    assign fq.in_data = net_data;
    assign net_ready = fq.in_ready;
    // the word leaves the FIFO in T3, after T1 has copied it out
    assign fq.out_ready = (d_state == HB_D_T3);

    logic [2:0] wait_cnt;
    logic first_xfer;
    logic is_remote;
    wire start = fq.out_valid && (dma_local_req || dma_remote_req);
    // only local bursts continue while data and demand remain
    wire more = !is_remote && dma_local_req && fq.out_valid; // see RL9
    assign dma_owned = !(d_state inside {HB_D_IDLE, HB_D_REQ, HB_D_SLIP});

    always_comb begin
        next_d_state = d_state;
        unique case (d_state)
            HB_D_IDLE: if (start) next_d_state = HB_D_REQ;
            HB_D_REQ: begin
                if (!grant_s) begin
                    next_d_state = HB_D_SLIP; // see RL8
                end else if (mode_32bit && first_xfer) begin
                    next_d_state = HB_D_PRIME; // see RL10
                end else begin
                    next_d_state = HB_D_T1;
                end
            end
            HB_D_SLIP: if (wait_cnt == 3'h0) next_d_state = HB_D_REQ;
            HB_D_PRIME: if (wait_cnt == 3'h0) next_d_state = HB_D_T1;
            HB_D_T1: next_d_state = HB_D_T2;
            HB_D_T2: next_d_state = HB_D_T3;
            HB_D_T3: next_d_state = HB_D_T4;
            HB_D_T4: next_d_state = more ? HB_D_T1 : HB_D_RELEASE; // see RL9
            HB_D_RELEASE: next_d_state = HB_D_IDLE;
            default: next_d_state = HB_D_IDLE;
        endcase
    end

    // slip and prime share one down counter; they never overlap
    wire load_wait = (next_d_state inside {HB_D_SLIP, HB_D_PRIME}) &&
        (d_state == HB_D_REQ);
    wire [2:0] load_val = (next_d_state == HB_D_SLIP) ?
        HB_SLIP_CYCLES - 3'h1 : HB_PRIME_CYCLES - 3'h1;
    wire in_xfer = next_d_state inside {HB_D_T1, HB_D_T2, HB_D_T3};
    wire owning = next_d_state inside {HB_D_PRIME, HB_D_T1, HB_D_T2,
        HB_D_T3, HB_D_T4};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            d_state <= HB_D_IDLE;
            wait_cnt <= 3'h0;
            first_xfer <= 1'b0;
            is_remote <= 1'b0;
        end else if (clk_en) begin
            d_state <= next_d_state;
            wait_cnt <= load_wait ? load_val : wait_cnt - 3'(wait_cnt != 0);
            if (d_state == HB_D_IDLE && start) begin
                first_xfer <= 1'b1;
                is_remote <= !dma_local_req;
            end else if (d_state == HB_D_T1) begin
                first_xfer <= 1'b0; // see RL10
            end
        end
    end

    // pin outputs; everything floats once the request drops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_request_out <= 1'b0;
            ctrl_oe_n <= 1'b1;
            lower_address_oe_n <= 1'b1;
            upper_address_lines_oe_n <= 1'b1;
            bus_data_oe_n <= 1'b1;
            addr_strobe_out_n <= 1'b1;
            mem_write_strobe_n <= 1'b1;
            dma_done <= 1'b0;
        end else if (clk_en) begin
            bus_request_out <= !(next_d_state inside {HB_D_IDLE,
                HB_D_RELEASE});
            ctrl_oe_n <= !owning; // see RL13
            lower_address_oe_n <= !in_xfer; // see RL13
            // byte mode holds the upper byte across the whole burst
            upper_address_lines_oe_n <= byte_mode ? !owning : !in_xfer; // see RL11
            bus_data_oe_n <= !in_xfer;
            addr_strobe_out_n <= (next_d_state != HB_D_T1);
            mem_write_strobe_n <= !(next_d_state inside {HB_D_T2, HB_D_T3});
            dma_done <= (next_d_state == HB_D_RELEASE);
        end
    end

    // address counts up per transfer; data copied at the first bus state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_address <= '0;
            bus_data_out <= HB_DATA_RST;
        end else if (clk_en) begin
            if (d_state == HB_D_IDLE && start) begin
                dma_address <= dma_start_addr;
            end else if (d_state == HB_D_T4) begin
                dma_address <= dma_address + 16'h0001;
            end
            if (next_d_state == HB_D_T1) begin
                bus_data_out <= fq.out_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n || !clk_en);

    sequence s_slip4;
        (d_state == HB_D_SLIP) [*4] ##1 (d_state == HB_D_REQ);
    endsequence
    sequence s_xfer;
        (d_state == HB_D_T1) ##1 (d_state == HB_D_T2) ##1
        (d_state == HB_D_T3) ##1 (d_state == HB_D_T4);
    endsequence

    property p_ack_rd;
        !access_ack_n |-> $past(cs_s) && ($past(rd_s) || $past(wr_s));
    endproperty
    a_ack_rd: assert property (p_ack_rd) else $error("ack without access"); // see RL1
    property p_ack_sync;
        $fell(access_ack_n) |-> $past(s_state) != HB_S_IDLE;
    endproperty
    a_ack_sync: assert property (p_ack_sync) else $error("ack too early"); // see RL2
    property p_ack_end;
        (!access_ack_n && !access) |=> access_ack_n;
    endproperty
    a_ack_end: assert property (p_ack_end) else $error("ack not released"); // see RL5
    property p_dma_first;
        $fell(access_ack_n) |-> !$past(dma_owned) && !dma_owned;
    endproperty
    a_dma_first: assert property (p_dma_first) else $error("ack during DMA"); // see RL4
    property p_decode;
        (reg_read_pulse || reg_write_pulse) |-> !access_ack_n &&
            $past(access_ack_n);
    endproperty
    a_decode: assert property (p_decode) else $error("decode off ack"); // see RL6
    property p_latch;
        ads_s |=> latched_register_select == $past(rs_s);
    endproperty
    a_latch: assert property (p_latch) else $error("latch not open"); // see RL7
    property p_slip;
        (d_state == HB_D_REQ && !grant_s) |=> s_slip4;
    endproperty
    a_slip: assert property (p_slip) else $error("slip not four"); // see RL8
    property p_remote;
        (d_state == HB_D_T1 && is_remote) |-> s_xfer ##1
            (d_state == HB_D_RELEASE);
    endproperty
    a_remote: assert property (p_remote) else $error("remote burst"); // see RL9
    property p_prime;
        (d_state == HB_D_PRIME) |-> first_xfer && mode_32bit;
    endproperty
    a_prime: assert property (p_prime) else $error("prime not first"); // see RL10
    property p_upper;
        (byte_mode && d_state == HB_D_T4 && more) |=>
            !upper_address_lines_oe_n;
    endproperty
    a_upper: assert property (p_upper) else $error("upper floated"); // see RL11
    property p_float;
        $fell(bus_request_out) |-> ctrl_oe_n && lower_address_oe_n &&
            upper_address_lines_oe_n;
    endproperty
    a_float: assert property (p_float) else $error("bus not released"); // see RL13
endmodule

// ==== verification/hb_arb_mem.sv ====
// bus arbiter and memory on the far side of the DMA master
`timescale 1ns/1ps
module hb_arb_mem
    import hb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic park,
    input wire logic bus_request_out,
    input wire logic mem_write_strobe_n,
    input wire logic bus_data_oe_n,
    input wire logic [HB_ADDR_W-1:0] dma_address,
    input wire logic [HB_DATA_W-1:0] bus_data_out,
    output logic bus_grant
);
    logic [HB_ADDR_W-1:0] log_addr [64];
    logic [HB_DATA_W-1:0] log_data [64];
    int wr_count;
    logic wr_prev;
    // a parked grant is set up before the first bus state; otherwise the
    // grant trails the request by an edge and the master has to slip
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bus_grant <= 1'b0;
            wr_prev <= 1'b1;
            wr_count <= 0;
        end else begin
            bus_grant <= park | bus_request_out;
            wr_prev <= mem_write_strobe_n;
            // one entry per strobe; undriven data is logged inverted
            if (wr_prev && !mem_write_strobe_n && wr_count < 64) begin
                log_addr[wr_count] <= dma_address;
                log_data[wr_count] <= bus_data_oe_n ? ~bus_data_out
                                                    : bus_data_out;
                wr_count <= wr_count + 1;
            end
        end
    end
endmodule

// ==== verification/hb_host_port_tb.sv ====
// self-checking bench for the host bus slave and DMA master
`timescale 1ns/1ps
module hb_host_port_tb
    import hb_pkg::*;
;
    logic ref_clk, nrst, chip_select_n, slave_read_strobe_n;
    logic slave_write_strobe_n, address_strobe_in, net_valid, net_ready;
    logic [HB_RS_W-1:0] register_select, latched_register_select;
    logic [HB_RS_W-1:0] decoded_register;
    logic access_ack_n, reg_read_pulse, reg_write_pulse, dma_done, park;
    logic dma_local_req, dma_remote_req, mode_32bit, byte_mode, bus_grant;
    logic bus_request_out, addr_strobe_out_n, mem_write_strobe_n, ctrl_oe_n;
    logic lower_address_oe_n, upper_address_lines_oe_n, bus_data_oe_n;
    logic [HB_DATA_W-1:0] net_data, bus_data_out;
    logic [HB_ADDR_W-1:0] dma_start_addr, dma_address;
    logic [HB_DATA_W-1:0] exp_q [$];
    logic [31:0] seed = 32'h000147E9;
    logic first_xfer = 1'b1;
    logic req_prev = 1'b0;
    int failures = 0;
    int cmp_count = 0;
    int gap = 0;

    hb_host_port i_hb_host_port (.ref_clk(ref_clk), .nrst(nrst),
        .clk_en(1'b1), .chip_select_n(chip_select_n),
        .slave_read_strobe_n(slave_read_strobe_n),
        .slave_write_strobe_n(slave_write_strobe_n),
        .address_strobe_in(address_strobe_in),
        .register_select(register_select), .access_ack_n(access_ack_n),
        .latched_register_select(latched_register_select),
        .decoded_register(decoded_register),
        .reg_read_pulse(reg_read_pulse), .reg_write_pulse(reg_write_pulse),
        .net_valid(net_valid), .net_data(net_data), .net_ready(net_ready),
        .dma_local_req(dma_local_req), .dma_remote_req(dma_remote_req),
        .mode_32bit(mode_32bit), .byte_mode(byte_mode),
        .dma_start_addr(dma_start_addr), .dma_done(dma_done),
        .bus_grant(bus_grant), .bus_request_out(bus_request_out),
        .addr_strobe_out_n(addr_strobe_out_n),
        .mem_write_strobe_n(mem_write_strobe_n), .ctrl_oe_n(ctrl_oe_n),
        .dma_address(dma_address), .lower_address_oe_n(lower_address_oe_n),
        .upper_address_lines_oe_n(upper_address_lines_oe_n),
        .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n));

    hb_arb_mem i_hb_arb_mem (.ref_clk(ref_clk), .nrst(nrst), .park(park),
        .bus_request_out(bus_request_out),
        .mem_write_strobe_n(mem_write_strobe_n),
        .bus_data_oe_n(bus_data_oe_n), .dma_address(dma_address),
        .bus_data_out(bus_data_out), .bus_grant(bus_grant));

    // 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // first bus state delay: a missed grant costs the slip plus a retry
    function automatic int first_delay(input logic m32, input logic pk);
        return (pk ? 1 : 2 + int'(HB_SLIP_CYCLES))
            + (m32 ? int'(HB_PRIME_CYCLES) : 0);
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic probe(input int sel);
        case (sel)
            0: return access_ack_n;
            1: return bus_request_out;
            2: return addr_strobe_out_n;
            3: return dma_done;
            default: return net_ready;
        endcase
    endfunction

    // count edges until a signal settles at a level, bounded
    task automatic wait_for(input int sel, input logic lvl, output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            @(negedge ref_clk);
            if (n > 400) begin
                failures++;
                $display("ERROR wait%0d expected %b seen timeout", sel, lvl);
                close_out();
            end
        end while (probe(sel) !== lvl);
    endtask

    // host cycle: select may trail the strobe by lag edges
    task automatic reg_access(input logic wr, input logic [3:0] rs,
        input int lag, input int lat, input logic [3:0] dec);
        int n;
        @(posedge ref_clk);
        register_select <= rs;
        slave_read_strobe_n <= wr;
        slave_write_strobe_n <= !wr;
        chip_select_n <= (lag != 0);
        // select trails the strobe; one drive per time step
        if (lag != 0) begin
            repeat (lag) @(posedge ref_clk);
            chip_select_n <= 1'b0;
        end
        wait_for(0, 1'b0, n);
        if (lat > 0) begin
            check("ack_delay", n, lat);
        end
        check("read_pulse", reg_read_pulse, !wr);
        check("write_pulse", reg_write_pulse, wr);
        check("decoded_register", decoded_register, dec);
        @(posedge ref_clk);
        chip_select_n <= 1'b1;
        slave_read_strobe_n <= 1'b1;
        slave_write_strobe_n <= 1'b1;
        wait_for(0, 1'b1, n);
        check("ack_rise", n, 3);
    endtask

    // fill side: hold valid until ready is seen at a sampling edge
    task automatic push_word(input logic [HB_DATA_W-1:0] d);
        int n;
        @(posedge ref_clk);
        net_valid <= 1'b1;
        net_data <= d;
        n = 0;
        @(negedge ref_clk);
        while (net_ready !== 1'b1 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 400) begin
            failures++;
            $display("ERROR fill_ready expected 1 seen timeout");
            close_out();
        end
        // ready stands until the next edge, which takes the word once
        @(posedge ref_clk);
        net_valid <= 1'b0;
        exp_q.push_back(d);
    endtask

    task automatic run_dma(input logic loc, input int words,
        input logic m32, input logic bm, input logic pk);
        int n, base, cnt;
        logic [HB_ADDR_W-1:0] ea;
        base = i_hb_arb_mem.wr_count;
        ea = HB_ADDR_W'(rnd());
        @(posedge ref_clk);
        park <= pk;
        mode_32bit <= m32;
        byte_mode <= bm;
        dma_start_addr <= ea;
        repeat (4) @(posedge ref_clk);
        for (int k = 0; k < words; k++) begin
            // fill before drain keeps the network side ahead of the bus
            push_word(HB_DATA_W'(rnd()));
        end
        @(negedge ref_clk);
        if (exp_q.size() == HB_FIFO_DEPTH) begin
            check("fifo_full", net_ready, 1'b0);
        end
        cnt = loc ? exp_q.size() : 1;
        @(posedge ref_clk);
        dma_local_req <= loc;
        dma_remote_req <= !loc;
        wait_for(1, 1'b1, n);
        wait_for(2, 1'b0, n);
        check("first_state", n, first_delay(m32, pk));
        wait_for(3, 1'b1, n);
        @(posedge ref_clk);
        dma_local_req <= 1'b0;
        dma_remote_req <= 1'b0;
        @(negedge ref_clk);
        check("transfers", i_hb_arb_mem.wr_count - base, cnt);
        for (int k = base; k < base + cnt; k++) begin
            check("address", i_hb_arb_mem.log_addr[k], ea);
            check("data", i_hb_arb_mem.log_data[k], exp_q.pop_front());
            ea = ea + 16'h0001;
        end
        $display("dma test done local %b words %0d", loc, cnt);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // ownership watch: burst spacing, enables and refused acknowledge
    always @(negedge ref_clk) begin
        if (nrst === 1'b1) begin
            if (ctrl_oe_n === 1'b0) begin
                check("ack_owned", access_ack_n, 1'b1);
            end
            if (ctrl_oe_n === 1'b0 && byte_mode === 1'b1) begin
                check("upper_oe", upper_address_lines_oe_n, 1'b0);
            end
            if (req_prev === 1'b1 && bus_request_out === 1'b0) begin
                check("release", {ctrl_oe_n, lower_address_oe_n,
                    upper_address_lines_oe_n, bus_data_oe_n}, 4'hF);
                first_xfer = 1'b1;
            end
            if (addr_strobe_out_n === 1'b0) begin
                if (!first_xfer) begin
                    check("burst_gap", gap, 4);
                end
                first_xfer = 1'b0;
                gap = 0;
            end
            gap++;
            req_prev = bus_request_out;
        end
    end

    // main sequence
    initial begin
        logic [31:0] r;
        {chip_select_n, slave_read_strobe_n, slave_write_strobe_n} = 3'h7;
        {address_strobe_in, net_valid, park} = 3'h4;
        {dma_local_req, dma_remote_req, mode_32bit, byte_mode} = 4'h0;
        register_select = 4'h0;
        net_data = 16'h0000;
        dma_start_addr = 16'h0000;
        nrst = 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            reg_access(r[0], r[7:4], int'(r[9:8]), 4, r[7:4]);
        end
        $display("register handshake test done");
        @(posedge ref_clk);
        register_select <= 4'hA;
        repeat (4) @(posedge ref_clk);
        address_strobe_in <= 1'b0;
        @(posedge ref_clk);
        register_select <= 4'h6;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        check("latch_hold", latched_register_select, 4'hA);
        reg_access(1'b0, 4'h5, 0, 4, 4'hA);
        @(posedge ref_clk);
        address_strobe_in <= 1'b1;
        $display("select latch test done");
        run_dma(1'b0, 2, 1'b0, 1'b0, 1'b1);
        run_dma(1'b0, 0, 1'b1, 1'b1, 1'b0);
        run_dma(1'b1, 3, 1'b0, 1'b1, 1'b1);
        run_dma(1'b1, 3, 1'b1, 1'b0, 1'b1);
        run_dma(1'b1, HB_FIFO_DEPTH, 1'b0, 1'b1, 1'b0);
        fork
            run_dma(1'b1, 4, 1'b0, 1'b0, 1'b1);
            begin
                wait_for(1, 1'b1, r);
                reg_access(1'b1, 4'h3, 0, 0, 4'h3);
            end
        join
        $display("access during ownership test done");
        close_out();
    end
endmodule
